// file: common/core_map.vh
// Address map, field positions, vectors and reset values of the core state block.
// Included by the design files; holds definitions only.
`ifndef CORE_MAP_VH
`define CORE_MAP_VH

// Data-memory addresses
`define ADDR_INDIRECT   7'h00
`define ADDR_MEM_PTR    7'h01
`define ADDR_WORK_REG   7'h05
`define ADDR_PC_LOW     7'h06
`define ADDR_TBL_PTR    7'h07
`define ADDR_TBL_HIGH   7'h08
`define ADDR_WDT_SEL    7'h09
`define ADDR_FLAGS      7'h0A
`define ADDR_IRQ_CTRL   7'h0B
`define ADDR_TIMER      7'h0D
`define ADDR_TIMER_CTRL 7'h0E
`define ADDR_PORT_LO    7'h12
`define ADDR_PORT_HI    7'h17
`define ADDR_RAM_BASE   7'h40

// Flag register bits
`define FLG_CARRY   0
`define FLG_NIBBLE  1
`define FLG_ZERO    2
`define FLG_WRAP    3
`define FLG_HALTED  4
`define FLG_WDT     5

// Interrupt control bits
`define IRQ_GLOBAL_EN 0
`define IRQ_EXT_EN    1
`define IRQ_TMR_EN    2
`define IRQ_EXT_PEND  4
`define IRQ_TMR_PEND  5

// Vectors and reset values
`define VEC_EXT        10'h004
`define VEC_TMR        10'h008
`define STACK_DEPTH    2'h2
`define RST_IRQ_CTRL   3'h0
`define RST_MEM_PTR    7'h00
`define RST_FLAGS      4'h0
`define RD_ZERO        8'h00
`define MEM_PTR_RD_B7  1'b1

`endif

// file: logic/core_state.v
// Core architectural state: return stack, data-memory map, flags, interrupts.
// Assumes the sequencer issues one operation per cycle and holds an access
// strobe for a single cycle; read data appear one cycle after the strobe.
// The interrupt pin is asynchronous and passes a two-flop synchroniser first.
//
// How it works
// [RULE1] Two-entry stack holds program counters only; no instruction reaches it.
// [RULE2] Calls and accepted interrupts push the pc; returns pop the latest entry.
// [RULE3] Chip reset empties the stack index.
// [RULE4] Full stack: pending flags still set, acknowledgement waits for a return.
// [RULE5] Call on a full stack drops the oldest entry.
// [RULE6] Sixty-four bytes of storage at 40H to 7FH.
// [RULE7] Special addresses are decoded at their fixed locations.
// [RULE8] Unassigned addresses below 40H read 00H.
// [RULE9] Address 00H is redirected through mem_pointer.
// [RULE10] Pointer of 00H: indirect read gives 00H, write is dropped.
// [RULE11] mem_pointer keeps seven bits; bit 7 reads one.
// [RULE12] Flag register at 0AH holds six status flags.
// [RULE13] Carry bit follows add carry, subtract no-borrow, rotate-through-carry.
// [RULE14] Nibble carry bit follows low-nibble carry or no-borrow.
// [RULE15] Zero bit set when the result is zero.
// [RULE16] Wrap bit set when carry in and out of msb differ.
// [RULE17] Writes to flags spare halted and watchdog bits; bits 6,7 read zero.
// [RULE18] Halted bit: cleared by power-up or watchdog clear, set by halt.
// [RULE19] Watchdog bit: cleared by power-up, clear or halt; set by time-out.
// [RULE20] Interrupt entry pushes only the pc, never the flags.
// [RULE21] Servicing an interrupt clears global_irq_enable.
// [RULE22] Falling external edge pends; service vectors to 04H and clears flags.
// [RULE23] Interrupt control layout: enables bits 0-2, pendings 4-5, rest zero.
// [RULE24] Timer overflow pends; service vectors to 08H and clears flags.
// [RULE25] Return from interrupt sets global enable; plain return leaves it.
// [RULE26] External request wins over timer request.
`timescale 1ns/10ps
`include "core_map.vh"
module core_state (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Program flow from the sequencer
  input  wire [9:0] pc,
  input  wire       subroutine_call_op,
  input  wire       return_op,
  input  wire       return_from_irq_op,
  output wire       irq_take,
  output reg  [9:0] irq_vector_ff,
  output wire [9:0] return_pc,
  output wire       stack_full,
  // Data-memory access
  input  wire       mem_rd,
  input  wire       mem_wr,
  input  wire [6:0] mem_addr,
  input  wire [7:0] mem_wdata,
  output reg  [7:0] mem_rdata_ff,
  // Values of registers kept outside this block
  input  wire [7:0] ext_reg_rdata,
  output wire       ext_reg_sel,
  // ALU flag update
  input  wire       alu_flags_we,
  input  wire [3:0] alu_flags_mask,
  input  wire       alu_carry,
  input  wire       alu_nibble_carry,
  input  wire [7:0] alu_result,
  input  wire       alu_carry_into_msb,
  // Power management and watchdog
  input  wire       halt_op,
  input  wire       watchdog_clear_op,
  input  wire       watchdog_timeout,
  // Interrupt sources
  input  wire       ext_irq_pin_n,
  input  wire       timer_overflow,
  // Architectural state seen by the core
  output wire [7:0] working_reg,
  output wire [7:0] flag_register,
  output wire [7:0] irq_control
);
  // Synchronised interrupt pin and edge detector
  reg       pin_meta_ff;
  reg       pin_sync_ff;
  reg       pin_prev_ff;
  // Architectural registers
  reg [6:0] mem_ptr_ff;
  reg [7:0] work_reg_ff;
  reg [3:0] alu_flags_ff;
  reg       halted_flag_ff;
  reg       watchdog_expired_ff;
  reg [2:0] irq_en_ff;
  reg       ext_irq_pending_ff;
  reg       timer_irq_pending_ff;
  // Read path holding registers
  localparam SRC_REG  = 1'b0;
  localparam SRC_RAM  = 1'b1;
  reg       rd_src_ff;
  reg [7:0] rd_hold_ff;
  // Decode results
  reg [6:0] eff_addr;
  reg       null_access;
  reg       ram_sel;
  reg       known_sel;
  reg [7:0] rd_mux;
  reg [3:0] nxt_alu_flags;
  wire      ext_edge;
  wire      flow_busy;
  wire      ext_take;
  wire      tmr_take;
  wire      push;
  wire      pop;
  wire      wr_ok;
  wire [7:0] ram_rdata;
  wire [1:0] stack_idx;

  // Two-flop synchroniser, edge detect reads only the second stage
  // Idle level is high, so the flops reset to one and no false edge follows reset
  always @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      pin_meta_ff <= ext_irq_pin_n;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end
  assign ext_edge = pin_prev_ff & ~pin_sync_ff;

  // Acknowledge only with global enable and a free stack level; external first.
  // An acknowledge waits out a cycle in which the sequencer moves the stack
  // itself, since a push and a pop together would lose a return address.
  assign flow_busy = subroutine_call_op | return_op | return_from_irq_op;
  assign ext_take  = irq_en_ff[`IRQ_GLOBAL_EN] & irq_en_ff[`IRQ_EXT_EN] & ext_irq_pending_ff & ~stack_full
                     & ~flow_busy; // [RULE4] [RULE22]
  assign tmr_take  = irq_en_ff[`IRQ_GLOBAL_EN] & irq_en_ff[`IRQ_TMR_EN] & timer_irq_pending_ff & ~stack_full
                     & ~flow_busy & ~ext_take; // [RULE26] [RULE24]
  assign irq_take = ext_take | tmr_take;

  // Only the pc is pushed; flags are never saved by hardware
  // Limitation: a call and a return in one cycle are not supported
  assign push = subroutine_call_op | irq_take; // [RULE2] [RULE20]
  assign pop  = return_op | return_from_irq_op; // [RULE2]

  // Vector register follows the acknowledged source
  // It stands until the next acknowledge; the sequencer loads it once
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_vector_ff <= 10'h000;
    end else if (ext_take) begin
      irq_vector_ff <= `VEC_EXT; // [RULE22]
    end else if (tmr_take) begin
      irq_vector_ff <= `VEC_TMR; // [RULE24]
    end
  end

  // Stack is hidden from the data-memory map entirely
  // Fullness is judged from the returned index register, the same test the stack uses
  return_stack u_stack ( // [RULE1]
    .clk                   (clk),
    .rst_n                 (rst_n),
    .push                  (push),
    .pop                   (pop),
    .push_pc               (pc),
    .top_pc                (return_pc),
    .full                  (),
    .return_stack_index_ff (stack_idx)
  );
  assign stack_full = (stack_idx == `STACK_DEPTH); // [RULE4]

  // Address 00H redirects through the pointer; pointer 00H is a null access
  always @* begin
    eff_addr    = mem_addr;
    null_access = 1'b0;
    if (mem_addr == `ADDR_INDIRECT) begin
      eff_addr    = mem_ptr_ff; // [RULE9]
      null_access = (mem_ptr_ff == `ADDR_INDIRECT); // [RULE10]
    end
  end

  // Decode: storage window, local registers, outside registers, else zero
  // Outside registers answer combinationally in the cycle of the select;
  // the gaps 02H-04H, 0CH, 0FH-11H and 18H-3FH fall through to zero
  always @* begin
    ram_sel   = 1'b0;
    known_sel = 1'b0;
    rd_mux    = `RD_ZERO;
    if (null_access) begin
      rd_mux = `RD_ZERO; // [RULE10]
    end else if (eff_addr >= `ADDR_RAM_BASE) begin
      ram_sel = 1'b1; // [RULE6]
    end else if (eff_addr == `ADDR_MEM_PTR) begin
      rd_mux = {`MEM_PTR_RD_B7, mem_ptr_ff}; // [RULE11]
    end else if (eff_addr == `ADDR_WORK_REG) begin
      rd_mux = work_reg_ff; // [RULE7]
    end else if (eff_addr == `ADDR_FLAGS) begin
      rd_mux = flag_register; // [RULE12]
    end else if (eff_addr == `ADDR_IRQ_CTRL) begin
      rd_mux = irq_control; // [RULE23]
    end else if (eff_addr == `ADDR_PC_LOW || eff_addr == `ADDR_TBL_PTR || eff_addr == `ADDR_TBL_HIGH
                 || eff_addr == `ADDR_WDT_SEL || eff_addr == `ADDR_TIMER || eff_addr == `ADDR_TIMER_CTRL
                 || (eff_addr >= `ADDR_PORT_LO && eff_addr <= `ADDR_PORT_HI)) begin
      known_sel = 1'b1; // [RULE7]
      rd_mux    = ext_reg_rdata;
    end else begin
      rd_mux = `RD_ZERO; // [RULE8]
    end
  end
  assign ext_reg_sel = known_sel & (mem_rd | mem_wr);
  assign wr_ok       = mem_wr & ~null_access; // [RULE10]

  // Storage writes only inside the window; reads run every cycle on the address
  ram64 u_ram (
    .clk        (clk),
    .wr_en      (wr_ok & ram_sel), // [RULE6]
    .wr_addr    (eff_addr[5:0]),
    .wr_data    (mem_wdata),
    .rd_addr    (eff_addr[5:0]),
    .rd_data_ff (ram_rdata)
  );

  // Register reads land in a holding flop so both sources share one latency
  always @(posedge clk) begin
    if (!rst_n) begin
      rd_hold_ff     <= `RD_ZERO;
      rd_src_ff      <= SRC_REG;
    end else begin
      rd_hold_ff     <= rd_mux;
      rd_src_ff      <= ram_sel ? SRC_RAM : SRC_REG;
    end
  end

  // Read data follow the address of the previous cycle from two registers.
  // Limitation: the sequencer must take them in the cycle after the strobe.
  always @* begin
    mem_rdata_ff = (rd_src_ff == SRC_RAM) ? ram_rdata : rd_hold_ff;
  end

  // Pointer keeps only the low seven bits of a write
  // Bit 7 is not stored; the read decode makes it up as one
  always @(posedge clk) begin
    if (!rst_n) begin
      mem_ptr_ff <= `RST_MEM_PTR;
    end else if (wr_ok && eff_addr == `ADDR_MEM_PTR) begin
      mem_ptr_ff <= mem_wdata[6:0]; // [RULE11]
    end
  end

  // Working register is an ordinary data-memory location
  always @(posedge clk) begin
    if (!rst_n) begin
      work_reg_ff <= 8'h00;
    end else if (wr_ok && eff_addr == `ADDR_WORK_REG) begin
      work_reg_ff <= mem_wdata;
    end
  end
  assign working_reg = work_reg_ff;

  // ALU flag update: mask bits pick which of C, AC, Z, OV the operation touches
  // A data write and an ALU update in one cycle merge bit by bit, ALU last
  always @* begin
    nxt_alu_flags = alu_flags_ff;
    if (wr_ok && eff_addr == `ADDR_FLAGS) begin
      nxt_alu_flags = mem_wdata[3:0]; // [RULE17]
    end
    if (alu_flags_we) begin
      if (alu_flags_mask[`FLG_CARRY]) begin
        nxt_alu_flags[`FLG_CARRY] = alu_carry; // [RULE13]
      end
      if (alu_flags_mask[`FLG_NIBBLE]) begin
        nxt_alu_flags[`FLG_NIBBLE] = alu_nibble_carry; // [RULE14]
      end
      if (alu_flags_mask[`FLG_ZERO]) begin
        nxt_alu_flags[`FLG_ZERO] = (alu_result == 8'h00); // [RULE15]
      end
      if (alu_flags_mask[`FLG_WRAP]) begin
        nxt_alu_flags[`FLG_WRAP] = alu_carry_into_msb ^ alu_carry; // [RULE16]
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      alu_flags_ff <= `RST_FLAGS;
    end else begin
      alu_flags_ff <= nxt_alu_flags; // [RULE12]
    end
  end

  // Halted and watchdog flags ignore data writes; clear op is taken over halt
  always @(posedge clk) begin
    if (!rst_n) begin
      halted_flag_ff      <= 1'b0; // [RULE18]
      watchdog_expired_ff <= 1'b0; // [RULE19]
    end else begin
      if (watchdog_clear_op) begin
        halted_flag_ff <= 1'b0; // [RULE18]
      end else if (halt_op) begin
        halted_flag_ff <= 1'b1; // [RULE18]
      end
      // A time-out in the clearing cycle still records, set wins
      if (watchdog_timeout) begin
        watchdog_expired_ff <= 1'b1; // [RULE19]
      end else if (watchdog_clear_op || halt_op) begin
        watchdog_expired_ff <= 1'b0; // [RULE19]
      end
    end
  end
  assign flag_register = {2'b00, watchdog_expired_ff, halted_flag_ff, alu_flags_ff}; // [RULE17]

  // Interrupt control: hardware set beats software clear on the pending flags
  // so an edge that lands in the cycle of a software clear is never lost;
  // an acknowledge beats a return from interrupt on the global enable
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_en_ff            <= `RST_IRQ_CTRL;
      ext_irq_pending_ff   <= 1'b0;
      timer_irq_pending_ff <= 1'b0;
    end else begin
      if (wr_ok && eff_addr == `ADDR_IRQ_CTRL) begin
        irq_en_ff            <= mem_wdata[2:0]; // [RULE23]
        ext_irq_pending_ff   <= mem_wdata[`IRQ_EXT_PEND];
        timer_irq_pending_ff <= mem_wdata[`IRQ_TMR_PEND];
      end
      if (irq_take) begin
        irq_en_ff[`IRQ_GLOBAL_EN] <= 1'b0; // [RULE21]
      end else if (return_from_irq_op) begin
        irq_en_ff[`IRQ_GLOBAL_EN] <= 1'b1; // [RULE25]
      end
      if (ext_edge) begin
        ext_irq_pending_ff <= 1'b1; // [RULE22] [RULE4]
      end else if (ext_take) begin
        ext_irq_pending_ff <= 1'b0; // [RULE22]
      end
      if (timer_overflow) begin
        timer_irq_pending_ff <= 1'b1; // [RULE24] [RULE4]
      end else if (tmr_take) begin
        timer_irq_pending_ff <= 1'b0; // [RULE24]
      end
    end
  end
  // Unused bits 3, 6 and 7 are tied to zero
  assign irq_control = {2'b00, timer_irq_pending_ff, ext_irq_pending_ff, 1'b0, irq_en_ff}; // [RULE23]
endmodule

// file: logic/ram64.v
// 64 x 8 general-purpose data storage with registered read data.
// Assumes the caller gates writes to the storage window only.
`timescale 1ns/10ps
module ram64 (
  // Clock
  input  wire       clk,
  // Write side
  input  wire       wr_en,
  input  wire [5:0] wr_addr,
  input  wire [7:0] wr_data,
  // Read side
  input  wire [5:0] rd_addr,
  output reg  [7:0] rd_data_ff
);
  reg [7:0] mem [0:63];

  // No reset: contents are undefined after power-up, as for real storage
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule

// file: logic/return_stack.v
// Two-entry return-address stack holding program-counter values only.
// Assumes push and pop are never asserted in the same cycle.
`timescale 1ns/10ps
`include "core_map.vh"
module return_stack (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Stack operations
  input  wire       push,
  input  wire       pop,
  input  wire [9:0] push_pc,
  // Stack state
  output wire [9:0] top_pc,
  output wire       full,
  output reg  [1:0] return_stack_index_ff
);
  reg [9:0] entry_ff [0:1];
  integer i;

  // Top entry is always slot 1 once filled; slot 0 holds the older one
  assign top_pc = (return_stack_index_ff == 2'd2) ? entry_ff[1] : entry_ff[0];
  assign full   = (return_stack_index_ff == `STACK_DEPTH);

  // Index counts entries in use; reset leaves the stack empty
  always @(posedge clk) begin
    if (!rst_n) begin
      return_stack_index_ff <= 2'd0; // [RULE3]
    end else if (push && !full) begin
      return_stack_index_ff <= return_stack_index_ff + 2'd1;
    end else if (pop && return_stack_index_ff != 2'd0) begin
      return_stack_index_ff <= return_stack_index_ff - 2'd1;
    end
  end

  // Entries: push when full shifts out the oldest return address
  always @(posedge clk) begin
    if (push) begin
      if (full) begin
        entry_ff[0] <= entry_ff[1]; // [RULE5]
        entry_ff[1] <= push_pc;
      end else begin
        for (i = 0; i < 2; i = i + 1) begin
          if (return_stack_index_ff == i) begin
            entry_ff[i] <= push_pc; // [RULE2]
          end
        end
      end
    end
  end
endmodule

// file: test/core_state_asserts.sv
// Checker: concurrent properties on the core state block ports.
// Bound to every core_state instance; one clock, sync active-low reset.
`timescale 1ns/10ps
module core_state_asserts (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Observed ports
  input wire       irq_take,
  input wire [9:0] irq_vector_ff,
  input wire       stack_full,
  input wire [7:0] irq_control,
  input wire [7:0] flag_register,
  input wire       mem_rd,
  input wire [6:0] mem_addr,
  input wire [7:0] mem_rdata_ff,
  input wire       return_from_irq_op,
  input wire       halt_op,
  input wire       watchdog_clear_op,
  input wire       watchdog_timeout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset must not be masked by itself, hence its own disable
  property p_rst;
    disable iff (1'b0) !rst_n |=> irq_control == 8'h00 && flag_register == 8'h00 && !stack_full;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  property p_nofull;
    irq_take |-> !stack_full;
  endproperty
  a_nofull: assert property (p_nofull) else $error("interrupt taken on full stack");
  property p_glob;
    irq_take |=> !irq_control[0];
  endproperty
  a_glob: assert property (p_glob) else $error("global enable kept on entry");
  // External request outranks the timer
  property p_vec;
    irq_take |=> irq_vector_ff == ($past(irq_control[4] & irq_control[1]) ? 10'h004 : 10'h008);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong interrupt vector");
  property p_unused;
    irq_control[7:6] == 2'h0 && !irq_control[3] && flag_register[7:6] == 2'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit reads one");
  property p_mp;
    mem_rd && mem_addr == 7'h01 |=> mem_rdata_ff[7];
  endproperty
  a_mp: assert property (p_mp) else $error("pointer bit 7 not one");
  property p_unmap;
    mem_rd && (mem_addr == 7'h02 || mem_addr == 7'h3F) |=> mem_rdata_ff == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unassigned address not zero");
  property p_return_from_irq_op;
    return_from_irq_op && !irq_take |=> irq_control[0];
  endproperty
  a_return_from_irq_op: assert property (p_return_from_irq_op) else $error("global enable not restored");
  property p_halt;
    halt_op && !watchdog_clear_op && !watchdog_timeout |=> flag_register[5:4] == 2'b01;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_clr;
    watchdog_clear_op && !watchdog_timeout |=> flag_register[5:4] == 2'b00;
  endproperty
  a_clr: assert property (p_clr) else $error("watchdog clear flags wrong");
  property p_tmo;
    watchdog_timeout |=> flag_register[5];
  endproperty
  a_tmo: assert property (p_tmo) else $error("time-out flag not set");
endmodule

bind core_state core_state_asserts u_chk (.clk, .rst_n, .irq_take, .irq_vector_ff, .stack_full, .irq_control,
  .flag_register, .mem_rd, .mem_addr, .mem_rdata_ff, .return_from_irq_op, .halt_op, .watchdog_clear_op,
  .watchdog_timeout);

// file: test/core_state_tb.sv
// Self-checking bench for the core state block; reads go through a queue.
// Assumes ext_reg_model answers the outside registers.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module core_state_tb;
  reg         clk       = 1'b0;
  reg         rst_n     = 1'b0;
  reg  [9:0]  pc        = 10'h000;
  reg  [7:0]  ops       = 8'h00;
  reg  [14:0] alu_in    = 15'h0000;
  reg         mem_rd    = 1'b0;
  reg         mem_wr    = 1'b0;
  reg  [6:0]  mem_addr  = 7'h00;
  reg  [7:0]  mem_wdata = 8'h00;
  reg         pin_n     = 1'b1;
  reg         rd_seen   = 1'b0;
  reg  [7:0]  exp_q[$];
  reg  [7:0]  d, d_exp;
  reg  [6:0]  a;
  reg  [9:0]  p1, p2;
  integer     failures = 0, n_tests = 0, cyc = 0, seed = 32'h31c0, i, j;
  wire        irq_take, stack_full, ext_reg_sel;
  wire [9:0]  irq_vector_ff, return_pc;
  wire [7:0]  mem_rdata_ff, ext_reg_rdata, working_reg, flag_register, irq_control;

  initial begin
    forever #5 clk = ~clk;
  end

  core_state u_dut (.clk(clk), .rst_n(rst_n), .pc(pc), .subroutine_call_op(ops[7]), .return_op(ops[6]),
    .return_from_irq_op(ops[5]), .irq_take(irq_take), .irq_vector_ff(irq_vector_ff), .return_pc(return_pc),
    .stack_full(stack_full), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata_ff(mem_rdata_ff), .ext_reg_rdata(ext_reg_rdata), .ext_reg_sel(ext_reg_sel),
    .alu_flags_we(ops[0]), .alu_flags_mask(alu_in[14:11]), .alu_carry(alu_in[10]),
    .alu_nibble_carry(alu_in[9]), .alu_carry_into_msb(alu_in[8]), .alu_result(alu_in[7:0]),
    .halt_op(ops[4]), .watchdog_clear_op(ops[3]), .watchdog_timeout(ops[2]), .ext_irq_pin_n(pin_n),
    .timer_overflow(ops[1]), .working_reg(working_reg), .flag_register(flag_register),
    .irq_control(irq_control));
  ext_reg_model u_ext (.clk(clk), .ext_reg_sel(ext_reg_sel), .ext_reg_rdata(ext_reg_rdata));

  // Scoreboard: read data stand the cycle after the strobe; also the hang limit
  always @(posedge clk) begin
    if (rd_seen) begin
      d_exp = exp_q.pop_front();
      `CHK("mem_rdata_ff", d_exp, mem_rdata_ff)
    end
    rd_seen <= mem_rd;
    cyc = cyc + 1;
    if (cyc == 4000) begin
      failures++;
      results;
    end
  end

  task rd(input [6:0] ad, input [7:0] e);
    begin
      @(posedge clk);
      mem_rd <= 1'b1;
      mem_addr <= ad;
      exp_q.push_back(e);
      @(posedge clk);
      mem_rd <= 1'b0;
    end
  endtask
  task wr(input [6:0] ad, input [7:0] v);
    begin
      @(posedge clk);
      mem_wr <= 1'b1;
      mem_addr <= ad;
      mem_wdata <= v;
      @(posedge clk);
      mem_wr <= 1'b0;
    end
  endtask
  // One-cycle pulse on the selected operation lines
  task op(input [7:0] o);
    begin
      @(posedge clk);
      ops <= o;
      @(posedge clk);
      ops <= 8'h00;
      #1;
    end
  endtask
  task stk(input f, input [9:0] v);
    begin
      `CHK("stack_full", f, stack_full)
      `CHK("return_pc", v, return_pc)
    end
  endtask
  // Bounded wait for the acknowledge, then the vector one edge later
  task take(input [9:0] v);
    begin
      #1;
      i = 0;
      while (irq_take !== 1'b1 && i < 20) begin
        @(negedge clk);
        i++;
      end
      `CHK("irq_take", 1'b1, irq_take)
      @(posedge clk);
      #1;
      `CHK("irq_vector_ff", v, irq_vector_ff)
    end
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("stack_full", 1'b0, stack_full)
    rd(7'h0A, 8'h00);
    rd(7'h0B, 8'h00);
    rd(7'h01, 8'h80);
    // Storage window, both ends included
    for (j = 0; j < 10; j++) begin
      a = j == 0 ? 7'h40 : j == 1 ? 7'h7F : 7'h40 | 7'($random(seed));
      d = 8'($random(seed));
      wr(a, d);
      rd(a, d);
    end
    wr(7'h05, d);
    #1;
    `CHK("working_reg", d, working_reg)
    rd(7'h05, d);
    d = 8'($random(seed));
    wr(7'h01, d);
    rd(7'h01, {1'b1, d[6:0]});
    wr(7'h01, 8'hC5);
    wr(7'h00, 8'h9A);
    rd(7'h45, 8'h9A);
    rd(7'h00, 8'h9A);
    wr(7'h01, 8'h00);
    wr(7'h00, 8'h77);
    rd(7'h00, 8'h00);
    rd(7'h45, 8'h9A);
    wr(7'h01, 8'h06);
    rd(7'h00, 8'h3C);
    rd(7'h06, 8'h3C);
    rd(7'h02, 8'h00);
    rd(7'h3F, 8'h00);
    // Flags from the ALU, full mask then partial
    alu_in <= {4'hF, 3'b110, 8'h00};
    op(8'h01);
    rd(7'h0A, 8'h0F);
    alu_in <= {4'h5, 3'b000, 8'h01};
    op(8'h01);
    rd(7'h0A, 8'h0A);
    wr(7'h0A, 8'hFF);
    rd(7'h0A, 8'h0F);
    wr(7'h0A, 8'h00);
    op(8'h10);
    rd(7'h0A, 8'h10);
    op(8'h04);
    rd(7'h0A, 8'h30);
    wr(7'h0A, 8'hFF);
    rd(7'h0A, 8'h3F);
    op(8'h10);
    rd(7'h0A, 8'h1F);
    op(8'h08);
    rd(7'h0A, 8'h0F);
    // Stack: fill, overflow, unwind
    p1 = 10'($random(seed));
    p2 = 10'($random(seed));
    pc <= p1;
    op(8'h80);
    stk(1'b0, p1);
    pc <= p2;
    op(8'h80);
    stk(1'b1, p2);
    pc <= ~p2;
    op(8'h80);
    stk(1'b1, ~p2);
    op(8'h40);
    stk(1'b0, p2);
    op(8'h40);
    // Interrupts held off by a full stack
    wr(7'h0B, 8'h07);
    pc <= p1;
    op(8'h80);
    op(8'h80);
    pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(negedge clk) `CHK("irq_take", 1'b0, irq_take)
    rd(7'h0B, 8'h17);
    op(8'h40);
    take(10'h004);
    stk(1'b1, p1);
    rd(7'h0B, 8'h06);
    op(8'h02);
    rd(7'h0B, 8'h26);
    op(8'h20);
    take(10'h008);
    rd(7'h0B, 8'h06);
    op(8'h40);
    op(8'h40);
    rd(7'h0B, 8'h06);
    wr(7'h0B, 8'h37);
    take(10'h004);
    rd(7'h0B, 8'h26);
    // Reset in mid-run with a full stack and a pending request
    pc <= p2;
    op(8'h80);
    stk(1'b1, p2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("stack_full", 1'b0, stack_full)
    rd(7'h0B, 8'h00);
    rd(7'h0A, 8'h00);
    rd(7'h01, 8'h80);
    repeat (2) @(posedge clk);
    `CHK("reads_left", 0, exp_q.size())
    results;
  end
endmodule

// file: test/ext_reg_model.sv
// Model of the registers kept outside the core state block.
// Answers in the cycle of the select; shows a moving pattern otherwise.
`timescale 1ns/10ps
module ext_reg_model (
  // Clock
  input  wire       clk,
  // Select from the block
  input  wire       ext_reg_sel,
  // Read value back
  output wire [7:0] ext_reg_rdata
);
  reg [7:0] junk_ff = 8'h00;
  // Unselected bus steps by 1DH every cycle and passes through every value, 3CH included
  always @(posedge clk) begin
    junk_ff <= junk_ff + 8'h1D;
  end
  assign ext_reg_rdata = ext_reg_sel ? 8'h3C : junk_ff;
endmodule
